/* File: rtl/secr_pkg.sv */
// Package for the system error capture register bank.
// Assumes a 32-bit APB with byte addresses as printed in the map.
package secr_pkg;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [31:0] SECR_FAIL_ADDRESS_ADDR = 32'h8000000c;
  localparam logic [31:0] SECR_FAIL_STATUS_ADDR = 32'h80000010;
  localparam logic [31:0] SECR_SEG2_END_ADDR = 32'h800000dc;
  localparam logic [31:0] SECR_PRODUCT_CONFIG_ADDR = 32'h80000024;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SECR_SEG2_END_MSB = 29;
  localparam int SECR_SEG2_END_LSB = 2;
  localparam int SECR_SEG2_UNPRIV_BIT = 1;
  localparam int SECR_SEG2_PRIV_BIT = 0;
  localparam int SECR_FS_EED_BIT = 9;
  localparam int SECR_FS_HED_BIT = 8;
  localparam int SECR_FS_TYPE_BIT = 7;
  localparam int SECR_FS_MOD_MSB = 6;
  localparam int SECR_FS_MOD_LSB = 3;
  localparam int SECR_FS_SIZE_MSB = 2;
  localparam int SECR_FS_SIZE_LSB = 0;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [31:0] SECR_SEG2_END_RST = 32'h00000000;
  localparam logic [31:0] SECR_FAIL_ADDRESS_RST = 32'h00000000;
  localparam logic [7:0] SECR_FAIL_STATUS_RST = 8'h00;
  localparam logic SECR_FLAG_RST = 1'b0;

  // ------------------------------------------------------------
  // Product configuration fields, msb first
  // ------------------------------------------------------------
  localparam logic SECR_PC_PAGING = 1'h0;
  localparam logic SECR_PC_DEBUG = 1'h1;
  localparam logic SECR_PC_SDRAM = 1'h1;
  localparam logic [2:0] SECR_PC_WATCHPOINTS = 3'h4;
  localparam logic SECR_PC_MAC = 1'h0;
  localparam logic [4:0] SECR_PC_WINDOWS = 5'h07;
  localparam logic [2:0] SECR_PC_ISET = 3'h3;
  localparam logic [1:0] SECR_PC_ILINE = 2'h3;
  localparam logic [2:0] SECR_PC_DSET = 3'h3;
  localparam logic [1:0] SECR_PC_DLINE = 2'h2;
  localparam logic [3:0] SECR_PC_DIV_MUL_WDOG_MEM = 4'hf;
  localparam logic [1:0] SECR_PC_FLOAT_KIND = 2'h1;
  localparam logic [1:0] SECR_PC_BRIDGE_KIND = 2'h1;
  localparam logic [1:0] SECR_PC_WPROT = 2'h1;
  localparam logic [31:0] SECR_PC_VALUE = {SECR_PC_PAGING, SECR_PC_DEBUG,
    SECR_PC_SDRAM, SECR_PC_WATCHPOINTS, SECR_PC_MAC, SECR_PC_WINDOWS,
    SECR_PC_ISET, SECR_PC_ILINE, SECR_PC_DSET, SECR_PC_DLINE,
    SECR_PC_DIV_MUL_WDOG_MEM, SECR_PC_FLOAT_KIND, SECR_PC_BRIDGE_KIND,
    SECR_PC_WPROT};

  // ------------------------------------------------------------
  // Capture field encodings
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    SECR_MOD_CORE = 4'h0,
    SECR_MOD_BRIDGE_INIT = 4'h1,
    SECR_MOD_BRIDGE_TGT = 4'h2,
    SECR_MOD_DEBUG_LINK = 4'h3
  } secr_module_t;

  typedef enum logic [2:0] {
    SECR_SIZE_BYTE = 3'h0,
    SECR_SIZE_HALF = 3'h1,
    SECR_SIZE_WORD = 3'h2,
    SECR_SIZE_DOUBLE = 3'h3
  } secr_size_t;

endpackage

/* File: rtl/secr_regs.sv */
// System error capture register bank: segment 2 end, product
// configuration, fail address and fail status, on an APB slave.
// Assumes error reporters give a one-cycle pulse per error and that
// all inputs are synchronous to mclk_i.
//
// Summary of operation
// - Segment 2 end address lives in bits 29:2, inclusive, word aligned.
// - Bit 1 enables segment 2 protection in unprivileged mode.
// - Bit 0 enables segment 2 protection in privileged mode.
// - Config reports eight register windows and no multiply-accumulate.
// - Config cache geometry: sets 011, instruction line 11, data line 10.
// - Config reports divide, multiply, watchdog, error registers, protection.
// - Fail address holds the full address of the failed access.
// - Fail address and capture fields are meaningful only while flag set.
// - Fail address writes are dropped while the error flag is clear.
// - Type, module and size writes are dropped while flag is clear.
// - Correctable memory error sets bit 9; only software clears it.
// - Bit 9 updates even while the hardware error flag is set.
// - Bit 8 resets to 0 and sets on any reported hardware error.
// - Flag is sticky; captures update only for errors while flag clear or cleared in that cycle.
// - Bit 7 gives direction of failed access: 0 write, 1 read.
// - Bits 6:3 give the source module of the failed access.
// - Bits 2:0 give the size of the failed access.
`timescale 1ns/10ps

module secr_regs (
  input wire logic mclk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Error reports
  input wire logic err_valid_i,
  input wire logic err_correctable_i,
  input wire logic [31:0] err_addr_i,
  input wire logic err_read_i,
  input wire secr_pkg::secr_module_t err_module_i,
  input wire secr_pkg::secr_size_t err_size_i,
  // Segment 2 protection view
  input wire logic privilege_flag_i,
  output logic [31:0] seg2_end_addr_o,
  output logic protect_in_unprivileged_o,
  output logic protect_in_privileged_o,
  output logic seg2_protect_active_o,
  output logic hw_error_o
);
  import secr_pkg::*;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [SECR_SEG2_END_MSB:SECR_SEG2_END_LSB] seg2_end;
  logic protect_in_unprivileged;
  logic protect_in_privileged;
  logic [31:0] fail_address;
  logic eed;
  logic hed;
  logic het;
  logic [3:0] hem;
  logic [2:0] hes;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic setup_phase;
  logic wr_access;
  logic hit_fa;
  logic hit_fs;
  logic hit_s2;
  logic hit_pc;
  logic hit_any;
  logic wr_fa;
  logic wr_fs;
  logic wr_s2;
  logic hed_clearing;
  logic err_accept;
  logic eed_set;

  // Zero-wait slave: every access phase completes at once
  assign pready_o = psel_i & penable_i;
  assign setup_phase = psel_i & ~penable_i;
  assign wr_access = psel_i & penable_i & pwrite_i;
  assign hit_fa = paddr_i == SECR_FAIL_ADDRESS_ADDR;
  assign hit_fs = paddr_i == SECR_FAIL_STATUS_ADDR;
  assign hit_s2 = paddr_i == SECR_SEG2_END_ADDR;
  assign hit_pc = paddr_i == SECR_PRODUCT_CONFIG_ADDR;
  assign hit_any = hit_fa | hit_fs | hit_s2 | hit_pc;
  assign wr_fa = wr_access & hit_fa;
  assign wr_fs = wr_access & hit_fs;
  assign wr_s2 = wr_access & hit_s2;

  // ------------------------------------------------------------
  // Error acceptance
  // ------------------------------------------------------------
  // A clear in the same cycle reopens capture, so no error is lost
  assign hed_clearing = wr_fs & ~pwdata_i[SECR_FS_HED_BIT];
  assign err_accept = err_valid_i & (~hed | hed_clearing);
  assign eed_set = err_valid_i & err_correctable_i;

  // ------------------------------------------------------------
  // Segment 2 end register
  // ------------------------------------------------------------
  // End field and mode qualifiers, word aligned
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      seg2_end <= SECR_SEG2_END_RST[SECR_SEG2_END_MSB:SECR_SEG2_END_LSB];
      protect_in_unprivileged <= SECR_FLAG_RST;
      protect_in_privileged <= SECR_FLAG_RST;
    end else if (wr_s2) begin
      seg2_end <= pwdata_i[SECR_SEG2_END_MSB:SECR_SEG2_END_LSB];
      protect_in_unprivileged <= pwdata_i[SECR_SEG2_UNPRIV_BIT];
      protect_in_privileged <= pwdata_i[SECR_SEG2_PRIV_BIT];
    end
  end

  // Low two address bits are never stored and are driven as zero on seg2_end_addr_o
  assign seg2_end_addr_o = {2'h0, seg2_end, 2'h0};
  assign protect_in_unprivileged_o = protect_in_unprivileged;
  assign protect_in_privileged_o = protect_in_privileged;

  // Qualifier picked by the current processor mode
  assign seg2_protect_active_o = privilege_flag_i ? protect_in_privileged
                                                  : protect_in_unprivileged;

  // ------------------------------------------------------------
  // Fail address
  // ------------------------------------------------------------
  // Capture wins over a software write in the same cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fail_address <= SECR_FAIL_ADDRESS_RST;
    end else if (err_accept) begin
      fail_address <= err_addr_i;
    end else if (wr_fa && hed) begin
      fail_address <= pwdata_i;
    end
  end

  // ------------------------------------------------------------
  // Fail status: sticky flags
  // ------------------------------------------------------------
  // Set beats software clear for both flags
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      eed <= SECR_FLAG_RST;
    end else if (eed_set) begin
      eed <= 1'b1;
    end else if (wr_fs) begin
      eed <= pwdata_i[SECR_FS_EED_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hed <= SECR_FLAG_RST;
    end else if (err_accept) begin
      hed <= 1'b1;
    end else if (wr_fs) begin
      hed <= pwdata_i[SECR_FS_HED_BIT];
    end
  end

  assign hw_error_o = hed;

  // ------------------------------------------------------------
  // Fail status: capture fields
  // ------------------------------------------------------------
  // Writes land only while a captured error is being held
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      {het, hem, hes} <= SECR_FAIL_STATUS_RST;
    end else if (err_accept) begin
      het <= err_read_i;
      hem <= err_module_i;
      hes <= err_size_i;
    end else if (wr_fs && hed) begin
      het <= pwdata_i[SECR_FS_TYPE_BIT];
      hem <= pwdata_i[SECR_FS_MOD_MSB:SECR_FS_MOD_LSB];
      hes <= pwdata_i[SECR_FS_SIZE_MSB:SECR_FS_SIZE_LSB];
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  logic [31:0] next_rdata;

  // Read mux; captures show raw storage, trusted only with flag set
  always_comb begin
    next_rdata = 32'h00000000;
    if (hit_fa) begin
      next_rdata = fail_address;
    end else if (hit_fs) begin
      next_rdata = {22'h000000, eed, hed, het, hem, hes};
    end else if (hit_s2) begin
      next_rdata = seg2_end_addr_o | {30'h00000000, protect_in_unprivileged,
                                      protect_in_privileged};
    end else if (hit_pc) begin
      next_rdata = SECR_PC_VALUE;
    end
  end

  // Data sampled in the setup cycle, held through the access phase
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (setup_phase) begin
      prdata_o <= pwrite_i ? 32'h00000000 : next_rdata;
      pslverr_o <= ~hit_any;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_hed_sets_on_err: assert property (
    err_valid_i |=> hed)
    else $error("error flag not set after error");

  a_hed_sticky_hold: assert property (
    hed && !wr_fs |=> hed)
    else $error("error flag dropped without a write");

  a_addr_capture_ok: assert property (
    err_valid_i && !hed |=> fail_address == $past(err_addr_i) && hed)
    else $error("failing address not captured");

  a_addr_frozen_held: assert property (
    !hed && !err_valid_i |=> $stable(fail_address))
    else $error("fail address changed while flag clear");

  a_fields_keep_first: assert property (
    hed && err_valid_i && !wr_fs && !wr_fa |=> $stable({het, hem, hes})
    && $stable(fail_address))
    else $error("second error overwrote capture");

  a_eed_sets_anyway: assert property (
    err_valid_i && err_correctable_i |=> eed)
    else $error("correctable flag not set");

  a_eed_no_hw_clear: assert property (
    eed && !wr_fs |=> eed)
    else $error("correctable flag cleared by hardware");

  a_type_capture_ok: assert property (
    err_accept |=> het == $past(err_read_i) && hes == $past(err_size_i)
    && hem == $past(err_module_i))
    else $error("type, module or size not captured");

  a_pcr_read_value: assert property (
    setup_phase && hit_pc && !pwrite_i ##1 pready_o |-> prdata_o == SECR_PC_VALUE)
    else $error("configuration read wrong");

  a_seg2_mode_pick: assert property (
    wr_s2 ##1 !wr_s2 && !privilege_flag_i |->
    seg2_protect_active_o == $past(pwdata_i[SECR_SEG2_UNPRIV_BIT]))
    else $error("unprivileged qualifier wrong");

  // Privileged mode follows bit 0 of the last write
  a_seg2_priv_pick: assert property (
    wr_s2 ##1 !wr_s2 && privilege_flag_i |->
    seg2_protect_active_o == $past(pwdata_i[SECR_SEG2_PRIV_BIT]))
    else $error("privileged qualifier wrong");

  // End address lands word aligned, top two bits dropped
  a_seg2_end_store: assert property (
    wr_s2 |=> seg2_end_addr_o ==
    {2'h0, $past(pwdata_i[SECR_SEG2_END_MSB:SECR_SEG2_END_LSB]), 2'h0})
    else $error("segment end not stored");

  // Segment end field moves only on its own write
  a_seg2_end_hold: assert property (
    !wr_s2 |=> $stable(seg2_end))
    else $error("segment end changed without a write");

  // Unprivileged qualifier holds between writes
  a_seg2_unpriv_hold: assert property (
    !wr_s2 |=> $stable(protect_in_unprivileged))
    else $error("unprivileged qualifier changed");

  // Privileged qualifier holds between writes
  a_seg2_priv_hold: assert property (
    !wr_s2 |=> $stable(protect_in_privileged))
    else $error("privileged qualifier changed");

  // Qualifier readback sits in bits 1:0
  a_seg2_read_view: assert property (
    setup_phase && hit_s2 && !pwrite_i |=>
    prdata_o[1:0] == $past({protect_in_unprivileged, protect_in_privileged}))
    else $error("segment qualifiers read wrong");

  // Fail address readback is the stored word
  a_fa_read_view: assert property (
    setup_phase && hit_fa && !pwrite_i |=> prdata_o == $past(fail_address))
    else $error("fail address read wrong");

  // Status readback: flags and captures, upper bits zero
  a_status_read_view: assert property (
    setup_phase && hit_fs && !pwrite_i |=>
    prdata_o == {22'h000000, $past({eed, hed, het, hem, hes})})
    else $error("fail status read wrong");

  // Address write is dropped while no error is held
  a_fa_write_dropped: assert property (
    wr_fa && !hed && !err_valid_i |=> $stable(fail_address))
    else $error("fail address write not dropped");

  // Address write lands while an error is held
  a_fa_write_lands: assert property (
    wr_fa && hed && !err_valid_i |=> fail_address == $past(pwdata_i))
    else $error("fail address write lost");

  // Capture fields frozen while the flag is clear
  a_fields_frozen_clear: assert property (
    !hed && !err_valid_i |=> $stable({het, hem, hes}))
    else $error("capture fields changed while flag clear");

  // Field write lands while an error is held
  a_fs_fields_write: assert property (
    wr_fs && hed && !err_valid_i |=>
    {het, hem, hes} == $past(pwdata_i[SECR_FS_TYPE_BIT:SECR_FS_SIZE_LSB]))
    else $error("capture field write lost");

  // Software can clear the correctable flag
  a_eed_clear_write: assert property (
    wr_fs && !pwdata_i[SECR_FS_EED_BIT] && !eed_set |=> !eed)
    else $error("correctable flag not cleared");

  // Only a correctable report or a status write raises the correctable flag
  a_eed_only_corr: assert property (
    !eed && !eed_set && !wr_fs |=> !eed)
    else $error("correctable flag set without cause");

  // First correctable error raises both flags together
  a_eed_sets_first: assert property (
    err_valid_i && err_correctable_i && !hed |=> eed && hed)
    else $error("correctable error flags not set");

  // Error flag rises only on a report or a status write
  a_hed_only_by_err: assert property (
    !hed && !err_valid_i && !wr_fs |=> !hed)
    else $error("error flag set without cause");

  // Software clear drops the error flag
  a_hed_clear_write: assert property (
    wr_fs && !pwdata_i[SECR_FS_HED_BIT] && !err_valid_i |=> !hed)
    else $error("error flag not cleared");

  // Held address is kept until software or a new capture
  a_fa_hold_set: assert property (
    hed && !err_accept && !wr_fa |=> $stable(fail_address))
    else $error("held fail address changed");

  // Source module captured with the flag
  a_module_capture: assert property (
    err_accept |=> hem == $past(err_module_i))
    else $error("source module not captured");

  // Access size captured with the flag
  a_size_capture: assert property (
    err_accept |=> hes == $past(err_size_i))
    else $error("access size not captured");

  // Detection beats a clear in the same cycle
  a_clear_race_wins: assert property (
    err_valid_i && hed_clearing |=> hed && fail_address == $past(err_addr_i))
    else $error("detection lost to a clear");

endmodule

/* File: testbench/secr_err_source.sv */
// Error reporter model: one-cycle error pulses toward the capture bank.
// Assumes callers of report() run in step with mclk_i.
`timescale 1ns/10ps

module secr_err_source (
  input wire logic mclk_i,
  output logic err_valid_o,
  output logic err_correctable_o,
  output logic [31:0] err_addr_o,
  output logic err_read_o,
  output secr_pkg::secr_module_t err_module_o,
  output secr_pkg::secr_size_t err_size_o
);
  import secr_pkg::*;
  // ------------------------------------------------------------
  // Idle lines and the report pulse
  // ------------------------------------------------------------
  initial begin
    err_valid_o = 1'b0;
    err_correctable_o = 1'b0;
    err_addr_o = 32'h0;
    err_read_o = 1'b0;
    err_module_o = SECR_MOD_CORE;
    err_size_o = SECR_SIZE_BYTE;
  end

  task automatic report(input logic [31:0] a, input logic r, input logic [3:0] m,
      input logic [2:0] s, input logic c);
    @(posedge mclk_i);
    err_valid_o <= 1'b1;
    err_correctable_o <= c;
    err_addr_o <= a;
    err_read_o <= r;
    err_module_o <= secr_module_t'(m);
    err_size_o <= secr_size_t'(s);
    @(posedge mclk_i);
    // Fields are dead after the pulse: inverted so stale copies never match
    err_valid_o <= 1'b0;
    err_correctable_o <= ~c;
    err_addr_o <= ~a;
    err_read_o <= ~r;
    err_module_o <= secr_module_t'(~m);
    err_size_o <= secr_size_t'(~s);
  endtask
endmodule

/* File: testbench/test_system_error_capture_regs.sv */
// Self-checking bench for the error capture bank, against a model.
// Assumes zero or more APB wait states and a one-cycle error pulse.
`timescale 1ns/10ps
`define SECR_CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module test_system_error_capture_regs;
  import secr_pkg::*;
  localparam logic [31:0] CFG_EXP = {1'b0, 1'b1, 1'b1, 3'b100, 1'b0, 5'b00111, 3'b011,
    2'b11, 3'b011, 2'b10, 4'b1111, 2'b01, 2'b01, 2'b01};
  logic mclk, rst, psel, penable, pwrite, priv, pready, pslverr, serr;
  logic ev, ec, er, hw_error, prot_u, prot_p, prot_act;
  logic [31:0] paddr, pwdata, prdata, ea, seg_addr, rd;
  secr_module_t em;
  secr_size_t es;
  int num_errors = 0;
  int total_checks = 0;
  int m_far = 0;
  int m_fsr = 0;
  int m_seg = 0;

  secr_regs u_secr_regs (.mclk_i(mclk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .err_valid_i(ev), .err_correctable_i(ec),
    .err_addr_i(ea), .err_read_i(er), .err_module_i(em), .err_size_i(es),
    .privilege_flag_i(priv), .seg2_end_addr_o(seg_addr), .protect_in_unprivileged_o(prot_u),
    .protect_in_privileged_o(prot_p), .seg2_protect_active_o(prot_act),
    .hw_error_o(hw_error));
  secr_err_source u_secr_err_source (.mclk_i(mclk), .err_valid_o(ev),
    .err_correctable_o(ec), .err_addr_o(ea), .err_read_o(er), .err_module_o(em),
    .err_size_o(es));

  // ------------------------------------------------------------
  // Bus master and model
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Model update for a register write, kept apart so a race can be ordered
  task automatic m_wr(input logic [31:0] a, input logic [31:0] d);
    if (a == SECR_SEG2_END_ADDR) m_seg = d & 32'h3fffffff;
    if (a == SECR_FAIL_ADDRESS_ADDR && m_fsr[8]) m_far = d;
    if (a == SECR_FAIL_STATUS_ADDR) m_fsr = (d & 32'h300) | ((m_fsr[8] ? d : m_fsr) & 32'hff);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    m_wr(a, d);
  endtask

  task automatic m_err(input logic [31:0] a, input logic [7:0] f, input logic c);
    if (!m_fsr[8]) begin
      m_far = a;
      m_fsr[7:0] = f;
    end
    m_fsr[8] = 1'b1;
    if (c) m_fsr[9] = 1'b1;
  endtask

  task automatic err(input logic [3:0] m, input logic [2:0] s, input logic c);
    logic [31:0] a;
    logic r;
    a = $urandom;
    r = 1'($urandom);
    u_secr_err_source.report(a, r, m, s, c);
    m_err(a, {r, m, s}, c);
  endtask

  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `SECR_CHK({serr, rd}, {1'b0, e})
  endtask

  task automatic chk_all();
    chk_rd(SECR_FAIL_ADDRESS_ADDR, m_far);
    chk_rd(SECR_FAIL_STATUS_ADDR, m_fsr);
    chk_rd(SECR_SEG2_END_ADDR, m_seg);
    @(negedge mclk);
    `SECR_CHK(hw_error, m_fsr[8])
    `SECR_CHK(seg_addr, 32'(m_seg) & 32'h3ffffffc)
    `SECR_CHK({prot_u, prot_p}, 2'(m_seg))
    `SECR_CHK(prot_act, priv ? m_seg[0] : m_seg[1])
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and tests
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Far above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    finish_test();
  end

  initial begin
    {rst, psel, penable, pwrite, priv, paddr, pwdata} = {5'b10000, 64'h0};
    void'($urandom(32'h5d4c));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    chk_all();
    wr(SECR_PRODUCT_CONFIG_ADDR, 32'h0);
    chk_rd(SECR_PRODUCT_CONFIG_ADDR, CFG_EXP);
    apb(1'b0, 32'h80000014, 32'h0);
    `SECR_CHK({serr, rd}, 33'h100000000)
    $display("test reset and config done");
    wr(SECR_FAIL_ADDRESS_ADDR, $urandom);
    wr(SECR_FAIL_STATUS_ADDR, $urandom & 32'hff);
    chk_all();
    $display("test writes while clear done");
    repeat (6) begin
      @(posedge mclk);
      priv <= 1'($urandom);
      wr(SECR_SEG2_END_ADDR, $urandom);
      chk_all();
    end
    $display("test segment end done");
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 4; s++) begin
        err(4'(m), 3'(s), 1'($urandom));
        err(4'($urandom % 4), 3'($urandom % 4), 1'b1);
        chk_all();
        wr(SECR_FAIL_ADDRESS_ADDR, $urandom);
        wr(SECR_FAIL_STATUS_ADDR, $urandom & 32'hff);
        chk_all();
      end
    end
    $display("test capture and clear done");
    err(4'h1, 3'h2, 1'b0);
    fork
      apb(1'b1, SECR_FAIL_STATUS_ADDR, 32'h0);
      begin
        // Pulse lands on the access edge of the status write
        @(posedge mclk);
        u_secr_err_source.report(32'h0badf00c, 1'b1, 4'h2, 3'h1, 1'b1);
      end
    join
    m_wr(SECR_FAIL_STATUS_ADDR, 32'h0);
    m_err(32'h0badf00c, {1'b1, 4'h2, 3'h1}, 1'b1);
    chk_all();
    $display("test clear against detection done");
    finish_test();
  end
endmodule
